/* pkg/pls_pkg.sv */
// Purpose: Shared constants for the indicator, strap and interrupt pin block
// Assumes: 125 MHz system clock
// Notes:   Register 0 and register 1f bit positions follow the management map

package pls_pkg;

   // ******************************************************
   // Register bus map
   // ******************************************************
   localparam logic [4:0] PLS_REG_CTRL      = 5'h00;
   localparam logic [4:0] PLS_REG_STAT      = 5'h01;
   localparam logic [4:0] PLS_REG_IRQ_STAT  = 5'h1b;
   localparam logic [4:0] PLS_REG_IRQ_MASK  = 5'h1c;
   localparam logic [4:0] PLS_REG_PHY_CTRL  = 5'h1f;

   // ******************************************************
   // Field positions
   // ******************************************************
   localparam int PLS_CTRL_SPEED_BIT   = 13;
   localparam int PLS_CTRL_ANEG_BIT    = 12;
   localparam int PLS_CTRL_DUPLEX_BIT  = 8;
   localparam int PLS_PHY_INT_POL_BIT  = 9;
   localparam int PLS_NUM_EVENTS       = 4;

   // Interrupt status register bit positions: link up, link down, collision, fault
   localparam int PLS_EV_LINK_UP   = 0;
   localparam int PLS_EV_LINK_DOWN = 1;
   localparam int PLS_EV_COLL      = 2;
   localparam int PLS_EV_FAULT     = 3;

   // ******************************************************
   // Reset values and timing
   // ******************************************************
   localparam logic [15:0] PLS_CTRL_RESET     = 16'h0000;
   localparam logic [15:0] PLS_PHY_CTRL_RESET = 16'h0000;
   localparam int          PLS_CLK_MHZ        = 125;
   localparam int          PLS_BLINK_MS       = 50;
   localparam int          PLS_BLINK_CYC      = PLS_BLINK_MS * 1000 * PLS_CLK_MHZ;

endpackage : pls_pkg

/* verilog/pls_sync2.sv */
// Purpose: Two-stage synchroniser for a group of pin inputs
// Assumes: Inputs are asynchronous to clk_sys
// Notes:   First stage is read only by the second

`timescale 1ns/1ps

module pls_sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk_sys,
   input  wire logic         reset,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_r;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end

endmodule : pls_sync2

/* verilog/pls_pins.sv */
// What this block does
// RULE1: Interrupt pin active level follows register 1f bit 9.
// RULE2: Interrupt pin strap during reset becomes station address bit 0.
// RULE3: Link/activity pin low with link, high without, toggles on activity.
// RULE4: Link/activity pin pulled low at reset selects factory test mode.
// RULE5: Speed pin high at 10, low at 100; strap loads speed bit.
// RULE6: Duplex pin high half, low full; strap loads register 0 bit 8.
// RULE7: Collision pin strap loads auto-negotiation enable, register 0 bit 12.
// RULE8: Straps sampled while reset is held; pins then revert to outputs.
// RULE9: Collision pin low during collision, high otherwise.
//
// Purpose: Dual-function indicator, strap and interrupt pins of the transceiver
// Assumes: Pins are open during reset so the external pull sets their level
// Notes:   Straps latch on the last reset cycle, read through synchronisers
//
// The address map and the address-and-strobe port were chosen for this implementation.

`timescale 1ns/1ps

module pls_pins
   import pls_pkg::*;
#(
   parameter int BLINK_CYC = PLS_BLINK_CYC
) (
   input  wire logic        clk_sys,
   input  wire logic        reset,
   input  wire logic [4:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   input  wire logic        link_up,
   input  wire logic        activity,
   input  wire logic        collision,
   input  wire logic        far_end_fault,
   input  wire logic        int_pin_i,
   output logic             int_pin_o,
   output logic             int_pin_oe,
   input  wire logic        link_activity_indicator_i,
   output logic             link_activity_indicator_o,
   output logic             link_activity_indicator_oe,
   input  wire logic        speed_indicator_i,
   output logic             speed_indicator_o,
   output logic             speed_indicator_oe,
   input  wire logic        duplex_indicator_i,
   output logic             duplex_indicator_o,
   output logic             duplex_indicator_oe,
   input  wire logic        collision_indicator_i,
   output logic             collision_indicator_o,
   output logic             collision_indicator_oe,
   output logic             station_addr_bit0,
   output logic             factory_test_mode,
   output logic             irq
);

   // ******************************************************
   // Pin synchronisers
   // ******************************************************
   logic [3:0] pin_s;
   logic [3:0] ev_s;

   pls_sync2 #(.W(4)) u_pin_sync (
      .clk_sys (clk_sys),
      .reset   (1'b0),
      .d       ({collision_indicator_i, duplex_indicator_i, speed_indicator_i, int_pin_i}),
      .q       (pin_s)
   );

   // Link status inputs come from PHY logic on the same clock
   assign ev_s = {far_end_fault, collision, activity, link_up};

   // ******************************************************
   // Strap capture
   // ******************************************************
   logic test_s_meta_r;
   logic test_s_r;
   logic strap_test_r;

   // Test strap has its own synchroniser; reset does not clear it
   always_ff @(posedge clk_sys) begin
      test_s_meta_r <= link_activity_indicator_i;
      test_s_r      <= test_s_meta_r;
   end

   // ******************************************************
   // Registers
   // ******************************************************
   logic [15:0] ctrl_r;
   logic [15:0] ctrl_nxt;
   logic [15:0] phy_ctrl_r;
   logic [3:0]  irq_stat_r;
   logic [3:0]  irq_stat_nxt;
   logic [3:0]  irq_mask_r;
   logic        addr0_r;
   logic        link_d_r;
   logic [3:0]  ev_set;
   logic        wr_ctrl;
   logic        wr_phy;
   logic        wr_istat;
   logic        wr_imask;
   logic [15:0] rd_mux;
   logic        int_pol;
   logic        int_active;

   assign wr_ctrl  = reg_wr && (reg_addr == PLS_REG_CTRL);
   assign wr_phy   = reg_wr && (reg_addr == PLS_REG_PHY_CTRL);
   assign wr_istat = reg_wr && (reg_addr == PLS_REG_IRQ_STAT);
   assign wr_imask = reg_wr && (reg_addr == PLS_REG_IRQ_MASK);

   // Straps hold the register while reset is high, last cycle wins
   always_comb begin
      ctrl_nxt = ctrl_r;
      if (reset) begin
         ctrl_nxt                      = PLS_CTRL_RESET;
         ctrl_nxt[PLS_CTRL_SPEED_BIT]  = pin_s[1];   // RULE5
         ctrl_nxt[PLS_CTRL_DUPLEX_BIT] = pin_s[2];   // RULE6
         ctrl_nxt[PLS_CTRL_ANEG_BIT]   = pin_s[3];   // RULE7
      end else if (wr_ctrl) begin
         ctrl_nxt = reg_wdata;
      end
   end

   // Pull-up strap (high) on speed pin means 100; low on duplex pin means half duplex
   always_ff @(posedge clk_sys) begin
      ctrl_r <= ctrl_nxt;  // RULE8
      if (reset) begin
         addr0_r      <= pin_s[0];    // RULE2
         strap_test_r <= ~test_s_r;   // RULE4
      end
   end

   assign ev_set = {ev_s[3], ev_s[2], link_d_r & ~ev_s[0], ~link_d_r & ev_s[0]};

   // Set wins over write-one-to-clear
   assign irq_stat_nxt = (irq_stat_r & ~(wr_istat ? reg_wdata[3:0] : 4'h0)) | ev_set;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         phy_ctrl_r <= PLS_PHY_CTRL_RESET;
         irq_stat_r <= 4'h0;
         irq_mask_r <= 4'h0;
         link_d_r   <= 1'b0;
      end else begin
         link_d_r   <= ev_s[0];
         irq_stat_r <= irq_stat_nxt;
         if (wr_phy) begin
            phy_ctrl_r <= reg_wdata;
         end
         if (wr_imask) begin
            irq_mask_r <= reg_wdata[3:0];
         end
      end
   end

   assign rd_mux = (reg_addr == PLS_REG_CTRL)     ? ctrl_r :
                   (reg_addr == PLS_REG_STAT)     ? {14'h0000, strap_test_r, addr0_r} :
                   (reg_addr == PLS_REG_IRQ_STAT) ? {12'h000, irq_stat_r} :
                   (reg_addr == PLS_REG_IRQ_MASK) ? {12'h000, irq_mask_r} :
                   (reg_addr == PLS_REG_PHY_CTRL) ? phy_ctrl_r : 16'h0000;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         reg_rdata <= rd_mux;
      end
   end

   // ******************************************************
   // Activity blink divider
   // ******************************************************
   logic [23:0] blink_cnt_r;
   logic        blink_tick;
   logic        blink_r;

   assign blink_tick = (blink_cnt_r == 24'(BLINK_CYC - 1));

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         blink_cnt_r <= 24'h000000;
         blink_r     <= 1'b0;
      end else begin
         blink_cnt_r <= blink_tick ? 24'h000000 : blink_cnt_r + 24'h000001;
         if (!ev_s[1]) begin
            blink_r <= 1'b0;
         end else if (blink_tick) begin
            blink_r <= ~blink_r;
         end
      end
   end

   // ******************************************************
   // Pin drivers
   // ******************************************************
   // Interrupt pin asserted level: bit 9 set means active high
   assign int_pol    = phy_ctrl_r[PLS_PHY_INT_POL_BIT];
   assign int_active = |(irq_stat_r & irq_mask_r);

   // Outputs released during reset so the strap pulls set the level
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         int_pin_o                  <= 1'b0;
         int_pin_oe                 <= 1'b0;
         link_activity_indicator_o  <= 1'b1;
         link_activity_indicator_oe <= 1'b0;
         speed_indicator_o          <= 1'b1;
         speed_indicator_oe         <= 1'b0;
         duplex_indicator_o         <= 1'b1;
         duplex_indicator_oe        <= 1'b0;
         collision_indicator_o      <= 1'b1;
         collision_indicator_oe     <= 1'b0;
         irq                        <= 1'b0;
      end else begin
         int_pin_o                  <= int_active ? int_pol : ~int_pol;            // RULE1
         int_pin_oe                 <= 1'b1;                                       // RULE8
         link_activity_indicator_o  <= ~ev_s[0] | blink_r;                         // RULE3
         link_activity_indicator_oe <= 1'b1;
         speed_indicator_o          <= ~ctrl_r[PLS_CTRL_SPEED_BIT];                // RULE5
         speed_indicator_oe         <= 1'b1;
         duplex_indicator_o         <= ~ctrl_r[PLS_CTRL_DUPLEX_BIT];               // RULE6
         duplex_indicator_oe        <= 1'b1;
         collision_indicator_o      <= ~ev_s[2];                                   // RULE9
         collision_indicator_oe     <= 1'b1;
         irq                        <= int_active;
      end
   end

   always_ff @(posedge clk_sys) begin
      station_addr_bit0 <= addr0_r;       // RULE2
      factory_test_mode <= strap_test_r;  // RULE4
   end

   // ******************************************************
   // Checks
   // ******************************************************
   // A strap only reaches its latch after four reset edges (release, two sync stages, latch)
   logic [3:0] rst_hist_r;
   logic       strap_settled;

   always_ff @(posedge clk_sys) begin
      rst_hist_r <= {rst_hist_r[2:0], reset};
   end

   assign strap_settled = &rst_hist_r;

   int_level_a: assert property (@(posedge clk_sys) disable iff (reset) // RULE1
      int_pin_oe && $past(int_pin_oe) |->
         int_pin_o == ($past(|(irq_stat_r & irq_mask_r)) ~^ $past(phy_ctrl_r[PLS_PHY_INT_POL_BIT])))
      else $error("interrupt pin level wrong");
   strap_addr_a: assert property (@(posedge clk_sys) // RULE2
      $fell(reset) && strap_settled |-> addr0_r == $past(pin_s[0]))
      else $error("address strap not latched");
   link_led_a: assert property (@(posedge clk_sys) disable iff (reset) // RULE3
      !reset && !ev_s[0] |=> link_activity_indicator_o)
      else $error("link indicator on without link");
   test_strap_a: assert property (@(posedge clk_sys) // RULE4
      $fell(reset) && strap_settled |-> strap_test_r == ~$past(test_s_r))
      else $error("test strap wrong");
   speed_strap_a: assert property (@(posedge clk_sys) // RULE5
      $fell(reset) && strap_settled |-> ctrl_r[PLS_CTRL_SPEED_BIT] == $past(pin_s[1]))
      else $error("speed strap wrong");
   duplex_strap_a: assert property (@(posedge clk_sys) // RULE6
      $fell(reset) && strap_settled |-> ctrl_r[PLS_CTRL_DUPLEX_BIT] == $past(pin_s[2]))
      else $error("duplex strap wrong");
   aneg_strap_a: assert property (@(posedge clk_sys) // RULE7
      $fell(reset) && strap_settled |-> ctrl_r[PLS_CTRL_ANEG_BIT] == $past(pin_s[3]))
      else $error("autoneg strap wrong");
   pins_released_a: assert property (@(posedge clk_sys) // RULE8
      reset ##1 reset |-> !speed_indicator_oe && !int_pin_oe && !collision_indicator_oe)
      else $error("pin driven during reset");
   coll_led_a: assert property (@(posedge clk_sys) disable iff (reset) // RULE9
      !reset && ev_s[2] |=> !collision_indicator_o)
      else $error("collision indicator off in collision");

endmodule : pls_pins

/* testbench/pls_far_end.sv */
// Purpose: Far side of the pins: pull resistors, indicator lamps, host interrupt input
// Assumes: Pin order {int, link, speed, duplex, collision}
// Notes:   Purely behavioural, no clock

`timescale 1ns/1ps

module pls_far_end (
   input  wire logic [4:0] pull_up,
   input  wire logic [4:0] pin_o,
   input  wire logic [4:0] pin_oe,
   output logic      [4:0] pin_lvl,
   output logic      [4:0] led_on
);
   // ******************************************************
   // Wire level
   // ******************************************************
   // A released pin falls to its pull, so the strap is what the block sees
   assign pin_lvl = (pin_oe & pin_o) | (~pin_oe & pull_up);
   // Lamps light when the pin sinks current
   assign led_on  = ~pin_lvl;
endmodule : pls_far_end

/* testbench/tb.sv */
// Purpose: Self-checking bench for the indicator, strap and interrupt pins
// Assumes: Blink half period shortened to 4 cycles
// Notes:   Straps need a longer reset than the first one to pass the synchronisers

`timescale 1ns/1ps

module tb;
   import pls_pkg::*;
   localparam int BLINK = 4;
   logic        clk_sys   = 1'b0;
   logic        reset     = 1'b1;
   logic [4:0]  reg_addr  = 5'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_wr    = 1'b0;
   logic        reg_rd    = 1'b0;
   logic [15:0] reg_rdata;
   logic [3:0]  ev        = 4'h0;
   logic [4:0]  pull_up   = 5'h1f;
   logic [4:0]  pin_o, pin_oe, pin_lvl, led_on, p;
   logic        irq, station_addr_bit0, factory_test_mode, last;
   logic [15:0] rd_val;
   int          errors    = 0;
   int          cmp_count = 0;
   int          toggles;
   // Rows: {link_up, collision, link pin, collision pin}
   logic [3:0]  rows [4]  = '{4'b0011, 4'b1001, 4'b0110, 4'b1100};

   always #4 clk_sys = ~clk_sys;

   pls_pins #(.BLINK_CYC(BLINK)) u_pls_pins (
      .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_up(ev[3]), .activity(ev[2]), .collision(ev[1]),
      .far_end_fault(ev[0]), .int_pin_i(pin_lvl[4]), .int_pin_o(pin_o[4]), .int_pin_oe(pin_oe[4]),
      .link_activity_indicator_i(pin_lvl[3]), .link_activity_indicator_o(pin_o[3]),
      .link_activity_indicator_oe(pin_oe[3]), .speed_indicator_i(pin_lvl[2]),
      .speed_indicator_o(pin_o[2]), .speed_indicator_oe(pin_oe[2]), .duplex_indicator_i(pin_lvl[1]),
      .duplex_indicator_o(pin_o[1]), .duplex_indicator_oe(pin_oe[1]), .collision_indicator_i(pin_lvl[0]),
      .collision_indicator_o(pin_o[0]), .collision_indicator_oe(pin_oe[0]),
      .station_addr_bit0(station_addr_bit0), .factory_test_mode(factory_test_mode), .irq(irq));

   pls_far_end u_pls_far_end (.pull_up(pull_up), .pin_o(pin_o), .pin_oe(pin_oe), .pin_lvl(pin_lvl),
      .led_on(led_on));

   // ******************************************************
   // Shared tasks
   // ******************************************************
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd

   task automatic give_verdict;
      $display("comparisons %0d errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : give_verdict

   // ******************************************************
   // Main sequence
   // ******************************************************
   initial begin
      tick(2);
      check({11'h0, pin_oe}, 16'h0000);
      @(posedge clk_sys);
      reset <= 1'b0;
      foreach (rows[i]) begin
         @(posedge clk_sys);
         ev <= {rows[i][3], 1'b0, rows[i][2], 1'b0};
         tick(3);
         check({14'h0, led_on[3], led_on[0]}, {14'h0, ~rows[i][1:0]});
      end
      // Mixed straps so that a swapped pair shows up
      for (int i = 0; i < 2; i++) begin
         p = i ? 5'b01010 : 5'b10101;
         @(posedge clk_sys);
         reset   <= 1'b1;
         pull_up <= p;
         tick(2);
         check({11'h0, pin_oe}, 16'h0000);
         repeat (4) @(posedge clk_sys);
         reset <= 1'b0;
         tick(3);
         check({11'h0, pin_oe}, 16'h001f);
         check({14'h0, factory_test_mode, station_addr_bit0}, {14'h0, ~p[3], p[4]});
         rd(PLS_REG_STAT, rd_val);
         check(rd_val, {14'h0, ~p[3], p[4]});
         rd(PLS_REG_CTRL, rd_val);
         check(rd_val, {2'b00, p[2], p[0], 3'h0, p[1], 8'h00});
         check({14'h0, pin_lvl[2:1]}, {14'h0, ~p[2], ~p[1]});
      end
      @(posedge clk_sys);
      ev <= 4'b1100;
      tick(2);
      toggles = 0;
      last = pin_lvl[3];
      for (int k = 0; k < 4 * BLINK; k++) begin
         tick(1);
         if (pin_lvl[3] !== last)
            toggles++;
         last = pin_lvl[3];
      end
      check({15'h0, toggles >= 3 && toggles <= 5}, 16'h0001);
      @(posedge clk_sys);
      ev <= 4'b0000;
      tick(2);
      wr(PLS_REG_IRQ_STAT, 16'h000f);
      wr(PLS_REG_IRQ_MASK, 16'h0004);
      rd(PLS_REG_IRQ_STAT, rd_val);
      check(rd_val, 16'h0000);
      check({14'h0, irq, pin_lvl[4]}, 16'h0001);
      @(posedge clk_sys);
      ev <= 4'b0011;
      @(posedge clk_sys);
      ev <= 4'b0000;
      tick(3);
      rd(PLS_REG_IRQ_STAT, rd_val);
      check(rd_val, 16'h000c);
      check({14'h0, irq, pin_lvl[4]}, 16'h0002);
      wr(PLS_REG_PHY_CTRL, 16'h0200);
      tick(3);
      check({14'h0, irq, pin_lvl[4]}, 16'h0003);
      wr(PLS_REG_IRQ_MASK, 16'h0000);
      tick(3);
      check({14'h0, irq, pin_lvl[4]}, 16'h0000);
      wr(PLS_REG_IRQ_STAT, 16'h0004);
      rd(PLS_REG_IRQ_STAT, rd_val);
      check(rd_val, 16'h0008);
      rd(5'h05, rd_val);
      check(rd_val, 16'h0000);
      give_verdict();
   end

   // Hang guard
   initial begin
      #100000;
      errors++;
      give_verdict();
   end
endmodule : tb
